// >>> include/emb_pkg.sv
package emb_pkg;
  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W       = 24;          // 16-megabyte linear space
  localparam int DATA_W       = 16;          // Widest external data path
  localparam int NUM_AREAS    = 3;           // Select and wait channels
  localparam int CLK_DIV      = 4;           // Clock pin divide ratio
  // ****************************************************************
  // Reset values and cycle counts
  // ****************************************************************
  localparam logic [1:0] DIV_RST = 2'h0;     // Divider phase after reset
  localparam int ADDR_CYC     = 1;           // Address phase length, cycles
  localparam int STROBE_CYC   = 2;           // Strobe phase length, cycles
  localparam int HOLD_CYC     = 1;           // Recovery after strobe, cycles
  localparam int SYNC_CYC     = 2;           // Pin synchroniser depth, cycles
  // Bus cycle states
  typedef enum logic [2:0] {
    EMB_IDLE, EMB_ADDR, EMB_STROBE, EMB_HOLD, EMB_GRANT
  } emb_state_type;
endpackage

// >>> hw/emb_bus_if.sv
`timescale 1ns/1ps
// How it works
// RULE1 - Read strobe shown for internal reads when enabled
// RULE2 - Low write strobe for data bits 0-7
// RULE3 - High write strobe for data bits 8-15
// RULE4 - Wait input holds strobe phase
// RULE5 - Bus request floats data, address, strobes, selects
// RULE6 - Grant asserted after pins float; the code asserts grant on the same edge that the output enables drop
// RULE7 - Direction high on read, low on write
// RULE8 - Select low while address in its area
// RULE9 - Three independent select and wait channels
// RULE10 - Low 16 address bits share data pins
// RULE11 - Latch strobe marks address, can be disabled
// RULE12 - Per-area 8 or 16 bit width, split accesses
// RULE13 - Width from area settings, not mode pin
// RULE14 - External master cannot reach internal memory
// RULE15 - Clock pin divides by four, high in reset
// RULE16 - Linear 16-megabyte space for code and data
// RULE17 - Reset floats latch strobe, pins to port mode
// RULE18 - Grant after cycle ends, released on request removal
module emb_bus_if
  import emb_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  // Core request side
  input  wire logic                  req_valid_i,       // Start of an access
  input  wire logic                  req_write_i,       // 1 write, 0 read
  input  wire logic                  req_dummy_i,       // Dummy cycle, direction high
  input  wire logic                  req_internal_i,    // Access targets internal memory
  input  wire logic [ADDR_W-1:0]     req_addr_i,
  input  wire logic [1:0]            req_byte_en_i,     // Bit 0 low lane, bit 1 high lane
  input  wire logic [DATA_W-1:0]     req_wdata_i,
  output logic                       req_ready_o,       // Access accepted
  output logic                       rsp_valid_o,       // Access finished
  output logic [DATA_W-1:0]          rsp_rdata_o,
  // Configuration bits
  input  wire logic                  bus_enable_i,      // Pins in bus mode, else port mode
  input  wire logic                  read_pin_enable_bit_i,
  input  wire logic                  read_pin_function_bit_i,
  input  wire logic                  latch_enable_i,    // Address latch strobe enable
  input  wire logic                  port1_wide_i,      // Port 1 carries data bits 8-15
  input  wire logic [NUM_AREAS-1:0]  area_en_i,
  input  wire logic [NUM_AREAS-1:0]  area_wide_i,       // 1 area is 16 bits wide
  input  wire logic [NUM_AREAS-1:0]  area_wait_en_i,    // Area honours wait pin
  input  wire logic [ADDR_W-1:0]     area_base_i [NUM_AREAS],
  input  wire logic [ADDR_W-1:0]     area_mask_i [NUM_AREAS],
  input  wire logic                  bus_width_mode_pin_i, // Strapped, unused for sizing
  // External pins
  input  wire logic [DATA_W-1:0]     ad_i,
  output logic [DATA_W-1:0]          ad_o,
  output logic [DATA_W-1:0]          ad_oe_o,
  output logic [ADDR_W-1:DATA_W]     addr_hi_o,
  output logic                       addr_hi_oe_o,
  output logic                       read_n_o,
  output logic                       write_n_o,
  output logic                       high_write_strobe_n_o,
  output logic                       strobe_oe_o,       // Read and both writes
  output logic                       rw_o,
  output logic [NUM_AREAS-1:0]       select_area_n_o,
  output logic                       select_oe_o,
  output logic                       latch_o,
  output logic                       latch_oe_o,
  input  wire logic                  wait_n_i,
  input  wire logic                  bus_request_n_i,
  output logic                       bus_grant_n_o,
  output logic                       clk_o,
  output logic                       port_mode_o        // Pins returned to port use
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [DATA_W-1:0] ad_s1_r, ad_s2_r;   // Data needs two stages too
  logic [1:0]        wait_s_r, breq_s_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ad_s1_r  <= '0;
      ad_s2_r  <= '0;
      wait_s_r <= 2'h3;
      breq_s_r <= 2'h3;
    end else begin
      ad_s1_r  <= ad_i;
      ad_s2_r  <= ad_s1_r;
      wait_s_r <= {wait_s_r[0], wait_n_i};
      breq_s_r <= {breq_s_r[0], bus_request_n_i};
    end
  end
  wire wait_req = ~wait_s_r[1];
  wire bus_req  = ~breq_s_r[1];

  // ****************************************************************
  // Clock pin divider
  // ****************************************************************
  logic [1:0] div_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) div_r <= DIV_RST;
    else div_r <= div_r + 2'h1;                    // see RULE15
  end
  // Pin held high in reset, then half period of two cycles
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) clk_o <= 1'b1;                  // see RULE15
    else clk_o <= ~div_r[1];                       // see RULE15
  end

  // ****************************************************************
  // Cycle state and captured request
  // ****************************************************************
  emb_state_type     st_r, st_nxt;
  logic [ADDR_W-1:0] addr_r;      // Full 24-bit address, see RULE16
  logic [DATA_W-1:0] wdata_r;
  logic [1:0]        be_r;
  logic              wr_r, dummy_r, int_r, second_r;
  logic [1:0]        cnt_r;

  // Area decode on the request address and on the captured address
  logic [NUM_AREAS-1:0] hit_req, hit_cur;
  for (genvar g = 0; g < NUM_AREAS; g++) begin : g_area  // see RULE9
    assign hit_req[g] = area_en_i[g] &
                        (((req_addr_i ^ area_base_i[g]) & ~area_mask_i[g]) == '0);
    assign hit_cur[g] = area_en_i[g] &
                        (((addr_r ^ area_base_i[g]) & ~area_mask_i[g]) == '0);  // see RULE8
  end
  // Priority: lowest area wins
  wire narrow_req = hit_req[0] ? ~area_wide_i[0] : hit_req[1] ? ~area_wide_i[1] :
                    hit_req[2] ? ~area_wide_i[2] : ~port1_wide_i;               // see RULE13
  wire narrow_cur = hit_cur[0] ? ~area_wide_i[0] : hit_cur[1] ? ~area_wide_i[1] :
                    hit_cur[2] ? ~area_wide_i[2] : ~port1_wide_i;               // see RULE12
  wire wait_ok = |(hit_cur & area_wait_en_i) | ~|hit_cur;                       // see RULE9
  // A narrow area with both lanes needs a second byte access
  wire split   = narrow_cur & (be_r == 2'h3) & ~second_r;                       // see RULE12

  wire start   = (st_r == EMB_IDLE) & req_valid_i & bus_enable_i & ~bus_req;
  // Wait-enabled strobes outlast the synchroniser, so a wait raised at strobe start is seen
  wire [1:0] strobe_min = wait_ok ? 2'(STROBE_CYC - 1 + SYNC_CYC) : 2'(STROBE_CYC - 1);
  wire strobe_done = (cnt_r >= strobe_min) & ~(wait_req & wait_ok);             // see RULE4
  // Reads linger in hold until the synchronised data pins carry the strobe's data
  wire [1:0] hold_min = wr_r ? 2'(HOLD_CYC - 1) : 2'(HOLD_CYC - 1 + SYNC_CYC);
  wire hold_end = (cnt_r == hold_min);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      EMB_IDLE:   if (bus_req) st_nxt = EMB_GRANT;                              // see RULE18
                  else if (start) st_nxt = EMB_ADDR;
      EMB_ADDR:   if (cnt_r == 2'(ADDR_CYC - 1)) st_nxt = EMB_STROBE;
      EMB_STROBE: if (strobe_done) st_nxt = EMB_HOLD;
      EMB_HOLD:   if (hold_end) st_nxt = split ? EMB_ADDR : EMB_IDLE;
      EMB_GRANT:  if (!bus_req) st_nxt = EMB_IDLE;                              // see RULE18
      default:    st_nxt = EMB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= EMB_IDLE;
      cnt_r <= 2'h0;
    end else begin
      st_r  <= st_nxt;
      // Saturate so a long wait never wraps the phase count
      cnt_r <= (st_nxt != st_r) ? 2'h0 : (cnt_r == 2'h3) ? cnt_r : cnt_r + 2'h1;
    end
  end

  // Capture request; second half moves to the odd byte
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_r <= '0; wdata_r <= '0; be_r <= 2'h0;
      wr_r <= 1'b0; dummy_r <= 1'b0; int_r <= 1'b0; second_r <= 1'b0;
    end else if (start) begin
      addr_r   <= req_addr_i;
      wdata_r  <= req_wdata_i;
      be_r     <= req_byte_en_i;
      wr_r     <= req_write_i;
      dummy_r  <= req_dummy_i;
      int_r    <= req_internal_i;
      second_r <= 1'b0;
    end else if (st_r == EMB_HOLD && st_nxt == EMB_ADDR) begin
      addr_r   <= addr_r | 24'h000001;                                          // see RULE12
      be_r     <= 2'h2;
      second_r <= 1'b1;
    end
  end

  // Read data: narrow areas return bytes on low lane
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rsp_rdata_o <= '0;
    else if (st_r == EMB_HOLD && hold_end && !wr_r) begin
      if (!narrow_cur) rsp_rdata_o <= ad_s2_r;
      else if (addr_r[0]) rsp_rdata_o[15:8] <= ad_s2_r[7:0];
      else rsp_rdata_o[7:0] <= ad_s2_r[7:0];
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire in_cycle  = (st_r == EMB_ADDR) | (st_r == EMB_STROBE) | (st_r == EMB_HOLD);
  wire ext_cyc   = in_cycle & ~int_r;
  wire drive_bus = bus_enable_i & (st_r != EMB_GRANT);                          // see RULE5
  wire rd_strobe = (st_r == EMB_STROBE) & ~wr_r &
                   (~int_r | (~read_pin_enable_bit_i & read_pin_function_bit_i)); // see RULE1
  // Byte lane write strobes; narrow odd byte still goes out on low lane
  // Dummy cycles keep direction high and so never strobe a write
  wire lo_wr = (st_r == EMB_STROBE) & ext_cyc & wr_r & ~dummy_r & (narrow_cur | be_r[0]); // see RULE2
  wire hi_wr = (st_r == EMB_STROBE) & ext_cyc & wr_r & ~dummy_r & ~narrow_cur & be_r[1];  // see RULE3
  wire [DATA_W-1:0] wdat = (narrow_cur & addr_r[0]) ? {8'h00, wdata_r[15:8]} : wdata_r;
  wire [DATA_W-1:0] ad_val = (st_r == EMB_ADDR) ? addr_r[15:0] : wdat;           // see RULE10
  wire ad_drv = drive_bus & ext_cyc & ((st_r == EMB_ADDR) | wr_r);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ad_o <= '0; ad_oe_o <= '0; addr_hi_o <= '0; addr_hi_oe_o <= 1'b0;
      read_n_o <= 1'b1; write_n_o <= 1'b1; high_write_strobe_n_o <= 1'b1;
      strobe_oe_o <= 1'b0; rw_o <= 1'b1; select_area_n_o <= '1; select_oe_o <= 1'b0;
      latch_o <= 1'b0; latch_oe_o <= 1'b0;                                      // see RULE17
      bus_grant_n_o <= 1'b1; port_mode_o <= 1'b1;                               // see RULE17
      req_ready_o <= 1'b0; rsp_valid_o <= 1'b0;
    end else begin
      ad_o          <= ad_val;
      ad_oe_o       <= {DATA_W{ad_drv}};
      addr_hi_o     <= addr_r[ADDR_W-1:DATA_W];
      addr_hi_oe_o  <= drive_bus;                                               // see RULE5
      read_n_o      <= ~rd_strobe;
      write_n_o     <= ~lo_wr;
      high_write_strobe_n_o <= ~hi_wr;
      strobe_oe_o   <= drive_bus;
      rw_o          <= ~(in_cycle & wr_r & ~dummy_r);                          // see RULE7
      select_area_n_o <= ~(hit_cur & {NUM_AREAS{ext_cyc}});                    // see RULE8
      select_oe_o   <= drive_bus;
      latch_o       <= (st_r == EMB_ADDR) & ext_cyc & latch_enable_i;          // see RULE11
      latch_oe_o    <= bus_enable_i & latch_enable_i;                          // see RULE11
      bus_grant_n_o <= ~(st_r == EMB_GRANT);                                    // see RULE6
      port_mode_o   <= ~bus_enable_i;
      req_ready_o   <= start;
      rsp_valid_o   <= (st_r == EMB_HOLD) & (st_nxt == EMB_IDLE);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_grant_floats;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !bus_grant_n_o |-> !strobe_oe_o && !select_oe_o && ad_oe_o == '0;
  endproperty
  a_grant_floats: assert property (p_grant_floats) // see RULE5
    else $error("grant while bus driven");
  // Grant register follows the state that the request sampled one edge earlier
  property p_grant_req;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $fell(bus_grant_n_o) |-> $past(bus_req);
  endproperty
  a_grant_req: assert property (p_grant_req) // see RULE18
    else $error("grant without request");
  property p_rw_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !write_n_o |-> !rw_o;
  endproperty
  a_rw_write: assert property (p_rw_write) // see RULE7
    else $error("write strobe with direction high");
  property p_rd_dir;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !read_n_o |-> rw_o && write_n_o && high_write_strobe_n_o;
  endproperty
  a_rd_dir: assert property (p_rd_dir) // see RULE7
    else $error("read strobe overlaps write");
  property p_wait_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_r == EMB_STROBE && wait_req && wait_ok) |=> st_r == EMB_STROBE;
  endproperty
  a_wait_hold: assert property (p_wait_hold) // see RULE4
    else $error("strobe ended under wait");
  property p_clk_div;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(clk_o) |=> clk_o ##1 !clk_o;
  endproperty
  a_clk_div: assert property (p_clk_div) // see RULE15
    else $error("clock pin not divided by four");
  property p_hi_narrow;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_r == EMB_STROBE && narrow_cur) |=> high_write_strobe_n_o;
  endproperty
  a_hi_narrow: assert property (p_hi_narrow) // see RULE3
    else $error("high strobe on narrow area");
  property p_latch_off;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(!latch_enable_i) |-> !latch_o;
  endproperty
  a_latch_off: assert property (p_latch_off) // see RULE11
    else $error("latch strobe while disabled");
endmodule // emb_bus_if

// >>> verif/emb_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// External memory with optional wait stretch
// ****************************************************************
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [DATA_W-1:0] ad_i,        // Device address/data out
  input  wire logic [DATA_W-1:0] ad_oe_i,
  input  wire logic              read_n_i,
  input  wire logic              write_n_i,
  input  wire logic              hi_n_i,
  input  wire logic [3:0]        wait_len_i,  // Wait cycles per strobe
  output logic     [DATA_W-1:0]  rdata_o,     // Drives device ad_i
  output logic                   wait_n_o
);
  logic [DATA_W-1:0] addr_r;                  // Captured low address
  logic [3:0]        wait_r;                  // Remaining wait cycles
  wire               stb_w = ~(read_n_i & write_n_i & hi_n_i);
  initial begin
    rdata_o = 16'h0;
    addr_r  = 16'h0;
    wait_r  = 4'h0;
  end
  // Address grabbed outside strobes; read data held until next address
  always @(posedge ref_clk_i) begin
    if (ad_oe_i != 16'h0 && !stb_w) begin
      addr_r  <= ad_i;
      rdata_o <= ~rdata_o;                    // Released lines never echo old data
      wait_r  <= wait_len_i;
    end else begin
      if (!read_n_i) rdata_o <= addr_r ^ 16'ha5c3;
      if (stb_w && wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
  end
  // Wait raised as soon as the strobe falls, held for the armed count
  assign wait_n_o = ~(stb_w && wait_r != 4'h0);
endmodule // emb_mem_model

// >>> verif/external_memory_bus_interface_tb.sv
`timescale 1ns/1ps
module external_memory_bus_interface_tb
  import emb_pkg::*;
;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic ref_clk_i, sys_rst_i, req_valid_i, req_write_i, req_internal_i, bus_width_mode_pin_i;
  logic [ADDR_W-1:0] req_addr_i, area_base_i [NUM_AREAS], area_mask_i [NUM_AREAS];
  logic [1:0] req_byte_en_i;
  logic rpe_i, rpf_i, latch_enable_i, port1_wide_i, bus_request_n_i, wait_n_i, req_dummy_i;
  logic [NUM_AREAS-1:0] area_en_i, area_wide_i, area_wait_en_i, select_area_n_o;
  logic [DATA_W-1:0] ad_i, ad_o, ad_oe_o, rsp_rdata_o;
  logic [ADDR_W-1:DATA_W] addr_hi_o;
  logic req_ready_o, rsp_valid_o, addr_hi_oe_o, read_n_o, write_n_o, high_write_strobe_n_o, strobe_oe_o;
  logic rw_o, select_oe_o, latch_o, latch_oe_o, bus_grant_n_o, clk_o, port_mode_o;
  logic [3:0] wait_len;
  int mismatches = 0, n_compared = 0, cycles = 0, cyc, lat_n, stb_n;
  logic rd_s, wr_s, hw_s, rw_s;
  logic [2:0] sel_s;
  logic [ADDR_W-1:0] lat_a;
  logic [DATA_W-1:0] rdata;
  emb_bus_if dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_dummy_i(req_dummy_i), .req_internal_i(req_internal_i), .req_addr_i(req_addr_i),
    .req_byte_en_i(req_byte_en_i), .req_wdata_i(16'h1234), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .bus_enable_i(1'b1), .read_pin_enable_bit_i(rpe_i), .read_pin_function_bit_i(rpf_i),
    .latch_enable_i(latch_enable_i), .port1_wide_i(port1_wide_i), .area_en_i(area_en_i), .area_wide_i(area_wide_i),
    .area_wait_en_i(area_wait_en_i), .area_base_i(area_base_i), .area_mask_i(area_mask_i),
    .bus_width_mode_pin_i(bus_width_mode_pin_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_o(addr_hi_oe_o), .read_n_o(read_n_o), .write_n_o(write_n_o), .strobe_oe_o(strobe_oe_o),
    .high_write_strobe_n_o(high_write_strobe_n_o), .rw_o(rw_o), .select_area_n_o(select_area_n_o),
    .select_oe_o(select_oe_o), .latch_o(latch_o), .latch_oe_o(latch_oe_o), .wait_n_i(wait_n_i),
    .bus_request_n_i(bus_request_n_i), .bus_grant_n_o(bus_grant_n_o), .clk_o(clk_o), .port_mode_o(port_mode_o));
  emb_mem_model mem (.ref_clk_i(ref_clk_i), .ad_i(ad_o), .ad_oe_i(ad_oe_o), .read_n_i(read_n_o),
    .write_n_i(write_n_o), .hi_n_i(high_write_strobe_n_o), .wait_len_i(wait_len), .rdata_o(ad_i), .wait_n_o(wait_n_i));
  // ****************************************************************
  // Clock, hang guard and shared tasks
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access from a falling edge, pins watched until it finishes
  task automatic acc(input logic wr, input logic intl, input logic [ADDR_W-1:0] a);
    logic stb, prev;
    begin
      {rd_s, wr_s, hw_s, rw_s, sel_s, lat_n, stb_n, prev} = {4'h1, 3'h7, 32'h0, 32'h0, 1'b0};
      {req_write_i, req_internal_i, req_addr_i, req_byte_en_i, req_valid_i} = {wr, intl, a, 2'h3, 1'b1};
      for (cyc = 0; cyc < 80 && rsp_valid_o !== 1'b1; cyc++) begin
        @(negedge ref_clk_i);
        if (req_ready_o === 1'b1) req_valid_i = 1'b0;
        if (latch_o === 1'b1) begin
          lat_n++;
          lat_a = {addr_hi_o, ad_o};
        end
        stb = !(read_n_o && write_n_o && high_write_strobe_n_o);
        if (stb && !prev) stb_n++;
        if (stb) begin
          {rd_s, wr_s, hw_s} = {rd_s, wr_s, hw_s} | ~{read_n_o, write_n_o, high_write_strobe_n_o};
          sel_s = sel_s & select_area_n_o;
        end
        // Direction watched over the strobe, and over the address phase while latch_o marks it
        if (stb || latch_o === 1'b1) rw_s = rw_s & rw_o;
        prev = stb;
      end
      rdata = rsp_rdata_o;
      @(negedge ref_clk_i);
      $display("access %h done in %0d cycles", a, cyc);
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_clock();
    int i;
    logic [7:0] c;
    @(negedge ref_clk_i);
    chk({clk_o, read_n_o, write_n_o, high_write_strobe_n_o, select_area_n_o, bus_grant_n_o}, 8'hff);
    chk({ad_oe_o, addr_hi_oe_o, strobe_oe_o, select_oe_o, latch_oe_o, port_mode_o}, 21'h1);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      c[i] = clk_o;
    end
    for (i = 0; i < 6; i++) chk(c[i+2], !c[i]);
    chk({port_mode_o, latch_oe_o}, 2'h1);
    $display("test reset and clock done");
  endtask
  task automatic t_writes();
    acc(1'b1, 1'b0, 24'h100246);
    chk({wr_s, hw_s, rw_s}, 3'h6);
    chk({sel_s, lat_n, stb_n}, {3'h6, 32'h1, 32'h1});
    chk(lat_a, 24'h100246);
    req_dummy_i = 1'b1;
    acc(1'b1, 1'b0, 24'h100246);
    chk({wr_s, hw_s, rw_s, stb_n}, {3'h1, 32'h0});
    req_dummy_i = 1'b0;
    bus_width_mode_pin_i = 1'b0;
    acc(1'b1, 1'b0, 24'h300100);
    chk({sel_s, lat_n, stb_n}, {3'h3, 32'h2, 32'h2});
    bus_width_mode_pin_i = 1'b1;
    acc(1'b1, 1'b0, 24'h300100);
    chk(stb_n, 2);
    $display("test writes done");
  endtask
  task automatic t_reads();
    int n0;
    acc(1'b0, 1'b0, 24'h200a10);
    chk({rd_s, rw_s, sel_s}, 5'h1d);
    chk(rdata, 16'h0a10 ^ 16'ha5c3);
    n0 = cyc;
    {wait_len, latch_enable_i} = {4'h6, 1'b0};
    acc(1'b0, 1'b0, 24'h200a10);
    chk(cyc > n0, 1);
    chk({lat_n, rdata}, {32'h0, 16'h0a10 ^ 16'ha5c3});
    {wait_len, latch_enable_i} = {4'h0, 1'b1};
    acc(1'b0, 1'b0, 24'h800000);
    chk({sel_s, stb_n}, {3'h7, 32'h1});
    acc(1'b0, 1'b0, 24'h300100);
    chk({stb_n, rdata}, {32'h2, 16'hc2c3});
    for (int r = 0; r < 2; r++) begin
      rpe_i = r[0];
      acc(1'b0, 1'b1, 24'h000040);
      chk({rd_s, sel_s}, {~r[0], 3'h7});
    end
    $display("test reads done");
  endtask
  // Outside master takes the bus; a core request is held off while granted, then withdrawn as the bus is released
  task automatic t_bus_request();
    int i;
    bus_request_n_i = 1'b0;
    for (i = 0; i < 20 && bus_grant_n_o !== 1'b0; i++) @(negedge ref_clk_i);
    chk(bus_grant_n_o, 0);
    chk({ad_oe_o, addr_hi_oe_o, strobe_oe_o, select_oe_o}, 20'h0);
    {req_write_i, req_internal_i, req_addr_i, req_valid_i} = {1'b0, 1'b0, 24'h100000, 1'b1};
    for (i = 0; i < 10; i++) begin
      @(negedge ref_clk_i);
      chk({req_ready_o, bus_grant_n_o}, 2'h0);
    end
    bus_request_n_i = 1'b1;
    req_valid_i = 1'b0;
    for (i = 0; i < 10 && bus_grant_n_o !== 1'b1; i++) @(negedge ref_clk_i);
    chk(bus_grant_n_o, 1);
    acc(1'b1, 1'b0, 24'h100010);
    chk({wr_s, sel_s}, 4'he);
    $display("test bus request done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {sys_rst_i, req_valid_i, req_write_i, req_internal_i, req_addr_i, req_byte_en_i} = {4'h8, 24'h0, 2'h3};
    {rpe_i, rpf_i, latch_enable_i, port1_wide_i, bus_request_n_i, bus_width_mode_pin_i} = 6'h1f;
    {area_en_i, area_wide_i, area_wait_en_i, wait_len} = {3'h7, 3'h3, 3'h2, 4'h0};
    area_base_i = '{24'h100000, 24'h200000, 24'h300000};
    area_mask_i = '{24'h0fffff, 24'h0fffff, 24'h0fffff};
    {rpe_i, req_dummy_i} = 2'h0;
    t_reset_clock();
    t_writes();
    t_reads();
    t_bus_request();
    finish_test();
  end
endmodule // external_memory_bus_interface_tb
